/* bench/dbgwm_pipe_model.sv */
// Behavioural model of the pipeline that issues memory and resource accesses.
`timescale 1ns/10ps
module dbgwm_pipe_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        en,
   output logic             acc_valid,
   output logic             acc_store,
   output logic      [31:0] acc_addr,
   output logic      [2:0]  acc_core,
   output logic             res_valid,
   output logic      [31:0] res_id,
   output logic      [2:0]  res_core
);
   ////////////////////////////////////////////////////////////////////////
   // Small address and identifier spaces make boundary hits frequent.
   // While idle the address and identifier buses invert every cycle, so a
   // stale value never passes for a fresh one.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_valid <= 1'b0;
         acc_store <= 1'b0;
         acc_addr  <= 32'h0000_0000;
         acc_core  <= 3'h0;
         res_valid <= 1'b0;
         res_id    <= 32'h0000_0000;
         res_core  <= 3'h0;
      end else begin
         acc_valid <= en & 1'($urandom_range(0, 1));
         acc_store <= 1'($urandom_range(0, 1));
         acc_addr  <= en ? 32'($urandom_range(0, 31)) : ~acc_addr;
         acc_core  <= 3'($urandom_range(0, 7));
         res_valid <= en & 1'($urandom_range(0, 1));
         res_id    <= en ? 32'($urandom_range(0, 15)) : ~res_id;
         res_core  <= 3'($urandom_range(0, 7));
      end
   end
endmodule

/* bench/tb.sv */
// Self-checking bench for the debug watchpoint matcher.
`timescale 1ns/10ps
module tb;
   logic        hclk, hresetn, hsel, hwrite, hready, en, mon;
   logic [31:0] haddr, hwdata, hrdata, cause_reg, cause_data, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, acc_core, res_core;
   logic        hreadyout, hresp, debug_irq, acc_valid, acc_store, res_valid;
   logic [31:0] acc_addr, res_id, e_cause, e_data;
   logic        e_irq;
   // Shadow of the six register groups, four entries each.
   logic [31:0] shd [6][4];
   logic [7:0]  bases [6] = '{dbgwm_pkg::IDX_FIRST, dbgwm_pkg::IDX_SECOND,
      dbgwm_pkg::IDX_DCTRL, dbgwm_pkg::IDX_RMASK, dbgwm_pkg::IDX_RVALUE,
      dbgwm_pkg::IDX_RCTRL};
   int          error_cnt, checks, cyc;

   // The single slave's ready out is the bus ready.
   assign hready = hreadyout;

   dbgwm_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .acc_valid(acc_valid),
      .acc_store(acc_store), .acc_addr(acc_addr), .acc_core(acc_core),
      .res_valid(res_valid), .res_id(res_id), .res_core(res_core),
      .debug_irq(debug_irq), .cause_reg(cause_reg),
      .cause_data(cause_data));

   dbgwm_pipe_model i_pipe (.hclk(hclk), .hresetn(hresetn), .en(en),
      .acc_valid(acc_valid), .acc_store(acc_store), .acc_addr(acc_addr),
      .acc_core(acc_core), .res_valid(res_valid), .res_id(res_id),
      .res_core(res_core));

   ////////////////////////////////////////////////////////////////////////
   // Clock at 250 MHz.
   always #2 hclk = ~hclk;

   // Counts a mismatch and reports it at once.
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One single-word transfer; holds each phase until ready is sampled.
   task automatic ahb(logic wr, logic [7:0] idx, logic [31:0] wd,
                      output logic [31:0] rdv);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask

   // Writes a register and records what should read back.
   task automatic cfg(int g, int k, logic [31:0] v);
      logic [31:0] m;
      m = (g == 2) ? dbgwm_pkg::DCTRL_WMASK :
          (g == 5) ? dbgwm_pkg::RCTRL_WMASK : 32'hFFFF_FFFF;
      ahb(1'b1, bases[g] + 8'(k), v, rd);
      shd[g][k] = v & m;
   endtask

   // Reads back every register against the shadow.
   task automatic verify_regs;
      for (int g = 0; g < 6; g++) begin
         for (int k = 0; k < 4; k++) begin
            ahb(1'b0, bases[g] + 8'(k), 32'h0000_0000, rd);
            chk("register", rd, shd[g][k]);
         end
      end
   endtask

   // Data hit: armed, core enabled, store or enabled load, range test.
   function automatic bit dhit(int k);
      logic [31:0] c;
      c = shd[2][k];
      if (!acc_valid || !c[0] || !c[16 + acc_core]) return 1'b0;
      if (!acc_store && !c[2]) return 1'b0;
      if (c[1]) return acc_addr <= shd[1][k] || acc_addr >= shd[0][k];
      return acc_addr >= shd[0][k] && acc_addr <= shd[1][k];
   endfunction

   // Resource hit: masked identifier compared, optionally inverted.
   function automatic bit rhit(int k);
      logic [31:0] c;
      c = shd[5][k];
      if (!res_valid || !c[0] || !c[16 + res_core]) return 1'b0;
      return ((res_id & shd[3][k]) == shd[4][k]) ^ c[1];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reference model; walking down the indices leaves the lowest one, and
   // the data pass runs last because a data hit beats a resource hit.
   always @(posedge hclk) begin
      e_irq = 1'b0;
      for (int k = 3; k >= 0; k--) begin
         if (rhit(k)) begin
            e_irq   = 1'b1;
            e_cause = {14'h0, 2'(k), 5'h0, res_core, 5'h0,
                       dbgwm_pkg::CAUSE_RES};
            e_data  = res_id;
         end
      end
      for (int k = 3; k >= 0; k--) begin
         if (dhit(k)) begin
            e_irq   = 1'b1;
            e_cause = {14'h0, 2'(k), 5'h0, acc_core, 5'h0,
                       dbgwm_pkg::CAUSE_DATA};
            e_data  = acc_addr;
         end
      end
      if (!hresetn) begin
         e_irq   = 1'b0;
         e_cause = dbgwm_pkg::REG_RESET;
         e_data  = dbgwm_pkg::REG_RESET;
      end
   end

   // Outputs are settled mid-cycle, so they are compared at the low edge.
   always @(negedge hclk) begin
      if (mon) begin
         chk("debug_irq", 32'(debug_irq), 32'(e_irq));
         chk("cause_reg", cause_reg, e_cause);
         chk("cause_data", cause_data, e_data);
      end
   end

   // A hang is cut short well above the expected run length.
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, reserved bits, then random rounds.
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      en = 1'b0;
      mon = 1'b0;
      foreach (shd[g, k]) shd[g][k] = dbgwm_pkg::REG_RESET;
      void'($urandom(43));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      mon <= 1'b1;
      verify_regs;
      // An unmapped index reads as zero.
      ahb(1'b0, 8'h00, 32'h0000_0000, rd);
      chk("unmapped", rd, 32'h0000_0000);
      // All ones shows which control bits are kept.
      foreach (shd[g, k]) cfg(g, k, 32'hFFFF_FFFF);
      verify_regs;
      repeat (5) begin
         foreach (shd[g, k]) begin
            cfg(g, k, (g < 2) ? 32'($urandom_range(0, 31)) :
                      (g < 5 && g > 2) ? 32'($urandom_range(0, 15)) :
                      $urandom);
         end
         verify_regs;
         en <= 1'b1;
         repeat (400) @(posedge hclk);
         en <= 1'b0;
         repeat (3) @(posedge hclk);
         // The bus view of the cause registers matches the captured hit.
         ahb(1'b0, dbgwm_pkg::IDX_CAUSE, 32'h0000_0000, rd);
         chk("cause via bus", rd, e_cause);
         ahb(1'b0, dbgwm_pkg::IDX_CDATA, 32'h0000_0000, rd);
         chk("data via bus", rd, e_data);
      end
      finish_test;
   end
endmodule

/* logic/dbgwm_matcher.sv */
// One data watchpoint and one resource watchpoint comparator pair.
`timescale 1ns/10ps
module dbgwm_matcher (
   input  wire logic [31:0] dctrl,
   input  wire logic [31:0] first_bound,
   input  wire logic [31:0] second_bound,
   input  wire logic [31:0] rctrl,
   input  wire logic [31:0] rmask,
   input  wire logic [31:0] rvalue,
   input  wire logic        acc_valid,
   input  wire logic        acc_store,
   input  wire logic [31:0] acc_addr,
   input  wire logic [2:0]  acc_core,
   input  wire logic        res_valid,
   input  wire logic [31:0] res_id,
   input  wire logic [2:0]  res_core,
   output logic             data_hit,
   output logic             res_hit
);
   logic in_range;      // Address inside the inclusive range.
   logic outside_open;  // Address outside the open inverted range.
   logic type_ok;       // Access kind allowed to trigger.
   logic dcore_ok;      // Issuing core enabled for the data watchpoint.
   logic rcore_ok;      // Issuing core enabled for the resource one.
   logic masked_eq;     // Masked identifier equals the compare value.

   assign in_range = (acc_addr >= first_bound) && (acc_addr <= second_bound);
   assign outside_open = (acc_addr <= second_bound) ||
                         (acc_addr >= first_bound);
   assign type_ok = acc_store || dctrl[dbgwm_pkg::CTRL_LOAD];
   assign dcore_ok = dctrl[dbgwm_pkg::CORE_LSB + {29'h0000_0000, acc_core}];
   assign rcore_ok = rctrl[dbgwm_pkg::CORE_LSB + {29'h0000_0000, res_core}];
   assign masked_eq = ((res_id & rmask) == rvalue);

   // Combine arm, core, type and the match sense for the data side.
   always_comb begin
      data_hit = acc_valid && dctrl[dbgwm_pkg::CTRL_ARM] && dcore_ok &&
                 type_ok && (dctrl[dbgwm_pkg::CTRL_INV] ? outside_open
                                                        : in_range);
   end

   // Resource side; the inverted sense fires on any mismatch.
   always_comb begin
      res_hit = res_valid && rctrl[dbgwm_pkg::CTRL_ARM] && rcore_ok &&
                (rctrl[dbgwm_pkg::CTRL_INV] ? !masked_eq : masked_eq);
   end
endmodule

/* logic/dbgwm_pkg.sv */
// Constants shared by the debug watchpoint matcher and its comparator.
package dbgwm_pkg;
   // Number of data and of resource watchpoints.
   localparam int          NUM_WATCH    = 4;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  IDX_FIRST    = 8'h50;
   localparam logic [7:0]  IDX_SECOND   = 8'h60;
   localparam logic [7:0]  IDX_DCTRL    = 8'h70;
   localparam logic [7:0]  IDX_RMASK    = 8'h80;
   localparam logic [7:0]  IDX_RVALUE   = 8'h90;
   localparam logic [7:0]  IDX_RCTRL    = 8'h9C;
   localparam logic [7:0]  IDX_CAUSE    = 8'h15;
   localparam logic [7:0]  IDX_CDATA    = 8'h16;
   // Control register field positions.
   localparam int          CTRL_ARM     = 0;
   localparam int          CTRL_INV     = 1;
   localparam int          CTRL_LOAD    = 2;
   localparam int          CORE_LSB     = 16;
   // Writable bits of the control and cause registers.
   localparam logic [31:0] DCTRL_WMASK  = 32'h00FF_0007;
   localparam logic [31:0] RCTRL_WMASK  = 32'h00FF_0003;
   localparam logic [31:0] CAUSE_WMASK  = 32'h0003_FF07;
   // Cause register field positions.
   localparam int          CAUSE_IDX_LSB  = 16;
   localparam int          CAUSE_CORE_LSB = 8;
   // Cause codes for the two watchpoint kinds.
   localparam logic [2:0]  CAUSE_DATA   = 3'h4;
   localparam logic [2:0]  CAUSE_RES    = 3'h5;
   // Values after reset.
   localparam logic [31:0] REG_RESET    = 32'h0000_0000;
endpackage

/* logic/dbgwm_top.sv */
// Debug watchpoint matcher: AHB-Lite registers, hit capture and assertions.
`timescale 1ns/10ps
module dbgwm_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        acc_valid,
   input  wire logic        acc_store,
   input  wire logic [31:0] acc_addr,
   input  wire logic [2:0]  acc_core,
   input  wire logic        res_valid,
   input  wire logic [31:0] res_id,
   input  wire logic [2:0]  res_core,
   output logic             debug_irq,
   output logic      [31:0] cause_reg,
   output logic      [31:0] cause_data
);
   localparam int N = dbgwm_pkg::NUM_WATCH;

   ////////////////////////////////////////////////////////////////////////
   // Register storage and comparator outputs.
   logic [31:0] first_bound  [N];   // Lower bound of each data range.
   logic [31:0] second_bound [N];   // Upper bound of each data range.
   logic [31:0] dctrl        [N];   // Data watchpoint control.
   logic [31:0] rmask        [N];   // Resource identifier mask.
   logic [31:0] rvalue       [N];   // Resource compare value.
   logic [31:0] rctrl        [N];   // Resource watchpoint control.
   logic [N-1:0] data_hit;          // Data comparators firing now.
   logic [N-1:0] res_hit;           // Resource comparators firing now.

   // Bus pipeline state.
   logic       wr_pend;             // A write is in its data phase.
   logic       rd_pend;             // A read is in its data phase.
   logic [7:0] ph_idx;              // Register index of that phase.
   logic       ph_ok;               // Address fell inside the map.
   logic       accept;              // Address phase taken this edge.
   logic [31:0] rd_mux;             // Read value for the pending index.

   assign accept = hsel && hready && htrans[1];

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture. Reads take one wait state so that
   // a read right after a write sees the value just written.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ph_idx  <= 8'h00;
         ph_ok   <= 1'b0;
      end else if (accept) begin
         wr_pend <= hwrite;
         rd_pend <= !hwrite;
         ph_idx  <= haddr[9:2];
         // Bits above the map read as zero and ignore writes.
         ph_ok   <= (haddr[31:10] == 22'h00_0000);
      end else if (hreadyout) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
      end
   end

   // Ready drops for the first data-phase cycle of a read only.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else if (accept && !hwrite) begin
         hreadyout <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   // The slave never signals an error; unmapped reads give zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // Read multiplexer on the pending index.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (ph_ok) begin
         case (ph_idx[7:2])
            dbgwm_pkg::IDX_FIRST[7:2]:  rd_mux = first_bound[ph_idx[1:0]];
            dbgwm_pkg::IDX_SECOND[7:2]: rd_mux = second_bound[ph_idx[1:0]];
            dbgwm_pkg::IDX_DCTRL[7:2]:  rd_mux = dctrl[ph_idx[1:0]];
            dbgwm_pkg::IDX_RMASK[7:2]:  rd_mux = rmask[ph_idx[1:0]];
            dbgwm_pkg::IDX_RVALUE[7:2]: rd_mux = rvalue[ph_idx[1:0]];
            dbgwm_pkg::IDX_RCTRL[7:2]:  rd_mux = rctrl[ph_idx[1:0]];
            default: begin
               if (ph_idx == dbgwm_pkg::IDX_CAUSE) begin
                  rd_mux = cause_reg;
               end else if (ph_idx == dbgwm_pkg::IDX_CDATA) begin
                  rd_mux = cause_data;
               end
            end
         endcase
      end
   end

   // Read data is registered in the wait cycle of the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend && !hreadyout) begin
         hrdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-watchpoint registers and comparators.
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_watch
         logic wr_here;   // Write data phase hits this entry's index.
         assign wr_here = wr_pend && ph_ok && (ph_idx[1:0] == g[1:0]);

         // Writes land in the data phase; control keeps reserved bits 0.
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               first_bound[g]  <= dbgwm_pkg::REG_RESET;
               second_bound[g] <= dbgwm_pkg::REG_RESET;
               dctrl[g]        <= dbgwm_pkg::REG_RESET;
               rctrl[g]        <= dbgwm_pkg::REG_RESET;
               rmask[g]        <= dbgwm_pkg::REG_RESET;
               rvalue[g]       <= dbgwm_pkg::REG_RESET;
            end else if (wr_here) begin
               case (ph_idx[7:2])
                  dbgwm_pkg::IDX_FIRST[7:2]:  first_bound[g]  <= hwdata;
                  dbgwm_pkg::IDX_SECOND[7:2]: second_bound[g] <= hwdata;
                  dbgwm_pkg::IDX_DCTRL[7:2]:
                     dctrl[g] <= hwdata & dbgwm_pkg::DCTRL_WMASK;
                  dbgwm_pkg::IDX_RMASK[7:2]:  rmask[g]  <= hwdata;
                  dbgwm_pkg::IDX_RVALUE[7:2]: rvalue[g] <= hwdata;
                  dbgwm_pkg::IDX_RCTRL[7:2]:
                     rctrl[g] <= hwdata & dbgwm_pkg::RCTRL_WMASK;
                  default: ;
               endcase
            end
         end

         dbgwm_matcher u_match (
            .dctrl        (dctrl[g]),
            .first_bound  (first_bound[g]),
            .second_bound (second_bound[g]),
            .rctrl        (rctrl[g]),
            .rmask        (rmask[g]),
            .rvalue       (rvalue[g]),
            .acc_valid    (acc_valid),
            .acc_store    (acc_store),
            .acc_addr     (acc_addr),
            .acc_core     (acc_core),
            .res_valid    (res_valid),
            .res_id       (res_id),
            .res_core     (res_core),
            .data_hit     (data_hit[g]),
            .res_hit      (res_hit[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Hit priority: data watchpoints before resource ones, and inside a
   // group the lowest index. A hit in the same cycle as a software write
   // to the cause registers wins, so no event is lost.
   logic [1:0] hit_idx;     // Lowest firing index in the winning group.
   logic       any_data;    // Some data watchpoint fires.
   logic       any_res;     // Some resource watchpoint fires.
   logic [N-1:0] win_vec;   // Hits of the winning group.

   assign any_data = |data_hit;
   assign any_res  = |res_hit;
   assign win_vec  = any_data ? data_hit : res_hit;

   // Scan downward so the lowest set bit is the last one kept.
   always_comb begin
      hit_idx = 2'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (win_vec[i]) begin
            hit_idx = i[1:0];
         end
      end
   end

   // Cause register: code, firing core and index.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_reg <= dbgwm_pkg::REG_RESET;
      end else if (any_data || any_res) begin
         cause_reg <= {14'h0000, hit_idx,
                       5'h00, any_data ? acc_core : res_core,
                       5'h00,
                       any_data ? dbgwm_pkg::CAUSE_DATA
                                : dbgwm_pkg::CAUSE_RES};
      end else if (wr_pend && ph_ok && ph_idx == dbgwm_pkg::IDX_CAUSE) begin
         cause_reg <= hwdata & dbgwm_pkg::CAUSE_WMASK;
      end
   end

   // Captured address or identifier of the triggering operation.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_data <= dbgwm_pkg::REG_RESET;
      end else if (any_data || any_res) begin
         cause_data <= any_data ? acc_addr : res_id;
      end else if (wr_pend && ph_ok && ph_idx == dbgwm_pkg::IDX_CDATA) begin
         cause_data <= hwdata;
      end
   end

   // Interrupt raised one edge after each triggering access; hits on consecutive cycles hold it high.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         debug_irq <= 1'b0;
      end else begin
         debug_irq <= any_data || any_res;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_data_fire;
      acc_valid && data_hit[0];
   endsequence
   sequence s_irq_data;
      debug_irq && cause_reg[2:0] == 3'h4 && cause_data == $past(acc_addr);
   endsequence

   data_cause_a: assert property (s_data_fire |=> s_irq_data)
      else $error("Data hit did not raise cause 4 with address.");

   res_cause_a: assert property (
      (res_hit[0] && !any_data) |=>
         debug_irq && cause_reg[2:0] == 3'h5 && cause_data == $past(res_id))
      else $error("Resource hit did not record cause 5 and id.");

   lowest_index_a: assert property (
      (data_hit[0] && data_hit[3]) |=> cause_reg[17:16] == 2'h0)
      else $error("Lowest firing watchpoint not reported.");

   disarmed_a: assert property (
      !dctrl[1][0] |-> !data_hit[1] && !res_hit[1] || rctrl[1][0])
      else $error("Disarmed data watchpoint fired.");

   load_gate_a: assert property (
      (acc_valid && !acc_store && !dctrl[2][2]) |-> !data_hit[2])
      else $error("Load triggered without load enable.");

   core_gate_a: assert property (
      (acc_valid && !dctrl[0][16 + acc_core]) |-> !data_hit[0])
      else $error("Disabled core triggered a watchpoint.");

   range_incl_a: assert property (
      (acc_valid && acc_store && dctrl[3][0] && !dctrl[3][1] &&
       dctrl[3][16 + acc_core] && acc_addr == first_bound[3] &&
       first_bound[3] <= second_bound[3]) |-> data_hit[3])
      else $error("Inclusive range missed its first bound.");

   range_inv_a: assert property (
      (acc_valid && dctrl[3][1] && acc_addr > second_bound[3] &&
       acc_addr < first_bound[3]) |-> !data_hit[3])
      else $error("Inverted range fired inside the open range.");

   mask_inv_a: assert property (
      (res_valid && rctrl[1][0] && rctrl[1][1] && rctrl[1][16 + res_core])
         |-> res_hit[1] == ((res_id & rmask[1]) != rvalue[1]))
      else $error("Inverted resource compare wrong.");

   ctrl_write_a: assert property (
      (wr_pend && ph_ok && ph_idx == 8'h70 && !hsel) |=>
         dctrl[0] == ($past(hwdata) & 32'h00FF_0007))
      else $error("Data control write not stored.");

   read_wait_a: assert property (
      (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("Read did not take exactly one wait state.");
endmodule
